// ### hdl/ahbs_map.vh
//----------------------------------------------------------------------
// Purpose: constants of the air heater burner sequencer
// Assumes: 10 MHz system clock, one-second sequencing tick
// Notes: all times in seconds unless named _NS
//----------------------------------------------------------------------
`ifndef AHBS_MAP_VH
`define AHBS_MAP_VH
//----------------------------------------------------------------------
// register map (byte addresses)
//----------------------------------------------------------------------
`define AHBS_REG_CTRL 8'h00
`define AHBS_REG_SETPT 8'h04
`define AHBS_REG_STATUS 8'h08
`define AHBS_REG_OUTPUT 8'h0C
`define AHBS_REG_DEMAND 8'h10
`define AHBS_CTRL_PETROL 0
`define AHBS_CTRL_RST 1'h0
`define AHBS_SETPT_RST 8'h80
`define AHBS_KW12_LEVEL 8'h60
//----------------------------------------------------------------------
// tick
//----------------------------------------------------------------------
`define AHBS_CLK_PERIOD_NS 100
`define AHBS_SEC_NS 1000000000
`define AHBS_TICK_CYCLES (`AHBS_SEC_NS / `AHBS_CLK_PERIOD_NS)
//----------------------------------------------------------------------
// sequence times in seconds
//----------------------------------------------------------------------
`define AHBS_T_BRK 16'h0001
`define AHBS_T_PUMP_D 16'h0014
`define AHBS_T_PUMP_P 16'h000F
`define AHBS_T_RAMP 16'h0019
`define AHBS_T_FAIL1_D 16'h0078
`define AHBS_T_FAIL1_P 16'h0073
`define AHBS_T_FAIL2_D 16'h0050
`define AHBS_T_FAIL2_P 16'h0055
`define AHBS_T_PURGE 16'h001E
`define AHBS_T_FAILRD 16'h0078
`define AHBS_T_STAB_D 16'h0014
`define AHBS_T_RISE_D 16'h0011
`define AHBS_T_RISE_P 16'h0004
`define AHBS_T_PERIOD 16'h0708
`define AHBS_T_REDUCE 16'h0014
`define AHBS_T_CUT 16'h0004
`define AHBS_T_NINE 16'h7E90
`define AHBS_T_MINW 16'h0005
`define AHBS_T_COOL 16'h009B
`define AHBS_T_SDOWN 16'h0023
`define AHBS_T_SMAX 16'h003C
`define AHBS_T_RDOWN 16'h0078
//----------------------------------------------------------------------
// fan and pump levels
//----------------------------------------------------------------------
`define AHBS_FAN_MAX 8'hFF
`define AHBS_FAN_23 8'hAA
`define AHBS_FAN_MID_D 8'h99
`define AHBS_FAN_MID_P 8'hBF
`define AHBS_FAN_LOW_D 8'h4D
`define AHBS_FAN_LOW_P 8'h80
`define AHBS_FAN_MIN 8'h33
`define AHBS_STEP_RAMP 8'h04
`define AHBS_STEP_RISE_D 8'h04
`define AHBS_STEP_RISE_P 8'h10
`define AHBS_STEP_DOWN 8'h02
`define AHBS_STEP_DEMAND 8'h08
`define AHBS_PUMP_START 8'h40
`define AHBS_PUMP_MIN 8'h20
`endif

// ### hdl/ahbs_tick.v
//----------------------------------------------------------------------
// Purpose: one-second tick prescaler of the system clock
// Assumes: TICK_CYCLES fits 24 bits
// Notes: tick_o is a one-cycle pulse
//----------------------------------------------------------------------
`include "ahbs_map.vh"
module ahbs_tick #(
	parameter TICK_CYCLES = `AHBS_TICK_CYCLES
) (
	input wire sys_clk_i, // system clock
	input wire rst_i, // async reset, high
	output reg tick_o // one-second pulse
);
	localparam [31:0] LAST_FULL = TICK_CYCLES - 1;
	localparam [23:0] LAST = LAST_FULL[23:0];
	reg [23:0] cnt;
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt <= 24'h000000;
			tick_o <= 1'b0;
		end else if (cnt >= LAST) begin
			cnt <= 24'h000000;
			tick_o <= 1'b1;
		end else begin
			cnt <= cnt + 24'h000001;
			tick_o <= 1'b0;
		end
	end
endmodule

// ### hdl/ahbs_sequencer.v
//----------------------------------------------------------------------
// Purpose: air heater burner sequencer with APB register access
// Assumes: intake temperature comes from same-clock logic; pins are async
// Notes on behaviour
// - overheat stops pump, shuts down via run-down
// - indicator steady when operating, flashing on overheat
// - switch on at power-up locks out until off
// - switch-on: indicator, glow cycling, one-second fan burst
// - too warm at switch-on: fan only, idle
// - pump after 20 s diesel, 15 s petrol
// - ramp fan 25 s after pump; flame stabilizes
// - no flame: 30 s purge, then repeat start
// - second failure: 120 s run-down, then lockout
// - diesel stabilization: glow, 20 s, 17 s ramp
// - petrol stabilization: glow, 4 s ramp
// - flame loss while stabilizing repeats start
// - diesel high output: reduce pump 20 s per 30 min
// - low output: cut fuel 4 s per 30 min
// - every 9 hours pause like control idle
// - above setpoint reduce; at minimum, pump off after 5 s
// - control operation: glow off, outputs follow demand
// - idle entry: 155 s at two thirds, then minimum
// - restart from control idle skips the fan burst
// - switch-off darkens indicator; early or idle stops immediately
// - fuelled switch-off: pump off, slow, max 60 s, 120 s run-down
// - switch-on during run-down waits for run-down end
//----------------------------------------------------------------------
`include "ahbs_map.vh"
module ahbs_sequencer #(
	parameter TICK_CYCLES = `AHBS_TICK_CYCLES
) (
	input wire sys_clk_i, // system clock, 10 MHz
	input wire rst_i, // async reset, high
	input wire psel_i, // APB select
	input wire penable_i, // APB enable
	input wire pwrite_i, // APB write
	input wire [7:0] paddr_i, // APB byte address
	input wire [31:0] pwdata_i, // APB write data
	output reg [31:0] prdata_o, // APB read data
	output wire pready_o, // APB ready
	output wire pslverr_o, // APB error on unmapped address
	input wire switch_on_i, // operator on/off, high = on, async
	input wire flame_i, // flame detected, async
	input wire overheat_i, // temperature limiter tripped, async
	input wire [7:0] intake_temp_i, // intake temperature, same clock
	output reg indicator_o, // operating indicator
	output reg glow_o, // glow plug drive
	output reg [7:0] fan_o, // fan speed, 0 = stopped
	output reg [7:0] pump_o // pump delivery rate, 0 = off
);
	//------------------------------------------------------------------
	// states
	//------------------------------------------------------------------
	localparam [13:0] S_INIT = 14'h0001;
	localparam [13:0] S_OFF = 14'h0002;
	localparam [13:0] S_LOCK = 14'h0004;
	localparam [13:0] S_IDLE = 14'h0008;
	localparam [13:0] S_START = 14'h0010;
	localparam [13:0] S_FUEL = 14'h0020;
	localparam [13:0] S_PURGE = 14'h0040;
	localparam [13:0] S_FAILRD = 14'h0080;
	localparam [13:0] S_STAB = 14'h0100;
	localparam [13:0] S_HEAT = 14'h0200;
	localparam [13:0] S_COOL = 14'h0400;
	localparam [13:0] S_SDOWN = 14'h0800;
	localparam [13:0] S_SMAX = 14'h1000;
	localparam [13:0] S_RDOWN = 14'h2000;

	reg [13:0] state;
	reg [13:0] next_state;
	reg [2:0] sync1;
	reg [2:0] sync2;
	reg [1:0] pwr_cnt;
	reg [15:0] sec_cnt;
	reg [15:0] per_cnt;
	reg [15:0] nine_cnt;
	reg [15:0] minw_cnt;
	reg [7:0] demand;
	reg petrol;
	reg [7:0] setpoint;
	reg ovh_lat;
	reg brk;
	reg attempt;
	reg blink;
	reg [7:0] next_pump;
	reg next_glow;
	reg next_ind;
	wire tick;
	wire sw_on;
	wire flame;
	wire ovh;
	wire too_warm;
	wire fuelled;
	wire [15:0] t_pump;
	wire [15:0] t_fail;
	wire [15:0] t_stab;
	wire [7:0] fan_low;
	wire [7:0] fan_mid;
	wire apb_wr;
	wire apb_setup;
	wire mapped;

	function [7:0] sat_up;
		input [7:0] val;
		input [7:0] step;
		input [7:0] lim;
		reg [8:0] sum;
		begin
			sum = {1'b0, val} + {1'b0, step};
			sat_up = (sum > {1'b0, lim}) ? lim : sum[7:0];
		end
	endfunction

	function [7:0] sat_dn;
		input [7:0] val;
		input [7:0] step;
		input [7:0] lim;
		begin
			sat_dn = (val < lim + step) ? lim : val - step;
		end
	endfunction

	//------------------------------------------------------------------
	// tick and pin synchronisers
	//------------------------------------------------------------------
	ahbs_tick #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.tick_o(tick)
	);

	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync1 <= 3'h0;
			sync2 <= 3'h0;
		end else begin
			sync1 <= {overheat_i, flame_i, switch_on_i};
			sync2 <= sync1;
		end
	end
	assign sw_on = sync2[0];
	assign flame = sync2[1];
	assign ovh = sync2[2];

	assign too_warm = intake_temp_i > setpoint;
	assign fuelled = (state == S_FUEL) || (state == S_STAB) || (state == S_HEAT);
	assign t_pump = petrol ? `AHBS_T_PUMP_P : `AHBS_T_PUMP_D;
	assign t_fail = attempt ? (petrol ? `AHBS_T_FAIL2_P : `AHBS_T_FAIL2_D)
		: (petrol ? `AHBS_T_FAIL1_P : `AHBS_T_FAIL1_D);
	assign t_stab = petrol ? `AHBS_T_RISE_P : (`AHBS_T_STAB_D + `AHBS_T_RISE_D);
	assign fan_low = petrol ? `AHBS_FAN_LOW_P : `AHBS_FAN_LOW_D;
	assign fan_mid = petrol ? `AHBS_FAN_MID_P : `AHBS_FAN_MID_D;

	//------------------------------------------------------------------
	// sequence control
	//------------------------------------------------------------------
	always @* begin
		next_state = state;
		case (state)
			S_INIT: begin
				if (pwr_cnt == 2'h3)
					next_state = sw_on ? S_LOCK : S_OFF;
			end
			S_OFF: begin
				if (sw_on)
					next_state = too_warm ? S_IDLE : S_START;
			end
			S_LOCK: begin
				if (!sw_on)
					next_state = S_OFF;
			end
			S_IDLE: begin
				if (!sw_on)
					next_state = S_OFF;
				else if (!too_warm)
					next_state = S_START;
			end
			S_START: begin
				if (!sw_on)
					next_state = S_OFF;
				else if (sec_cnt >= t_pump)
					next_state = S_FUEL;
			end
			S_FUEL: begin
				if (!sw_on)
					next_state = S_SDOWN;
				else if (flame)
					next_state = S_STAB;
				else if (sec_cnt >= t_fail)
					next_state = attempt ? S_FAILRD : S_PURGE;
			end
			S_PURGE: begin
				if (sec_cnt >= `AHBS_T_PURGE)
					next_state = sw_on ? S_START : S_RDOWN;
			end
			S_FAILRD: begin
				if (sec_cnt >= `AHBS_T_FAILRD)
					next_state = S_LOCK;
			end
			S_STAB: begin
				if (!sw_on)
					next_state = S_SDOWN;
				else if (!flame)
					next_state = S_START;
				else if (sec_cnt >= t_stab)
					next_state = S_HEAT;
			end
			S_HEAT: begin
				if (!sw_on)
					next_state = S_SDOWN;
				else if (!flame)
					next_state = S_SMAX;
				else if (nine_cnt >= `AHBS_T_NINE)
					next_state = S_COOL;
				else if (minw_cnt >= `AHBS_T_MINW)
					next_state = S_COOL;
			end
			S_COOL: begin
				if (!sw_on)
					next_state = S_OFF;
				else if (sec_cnt >= `AHBS_T_COOL)
					next_state = S_IDLE;
			end
			S_SDOWN: begin
				if (!flame || fan_o <= `AHBS_FAN_23 || sec_cnt >= `AHBS_T_SDOWN)
					next_state = S_SMAX;
			end
			S_SMAX: begin
				if (sec_cnt >= `AHBS_T_SMAX)
					next_state = S_RDOWN;
			end
			S_RDOWN: begin
				if (sec_cnt >= `AHBS_T_RDOWN) begin
					if (ovh_lat)
						next_state = S_LOCK;
					else
						next_state = sw_on ? S_START : S_OFF;
				end
			end
			default: next_state = S_INIT;
		endcase
		if (ovh && fuelled)
			next_state = S_SDOWN;
		else if (ovh && ((state == S_START) || (state == S_IDLE) || (state == S_COOL)))
			next_state = S_RDOWN;
	end

	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= S_INIT;
			pwr_cnt <= 2'h0;
			sec_cnt <= 16'h0000;
			ovh_lat <= 1'b0;
			brk <= 1'b0;
			attempt <= 1'b0;
			blink <= 1'b0;
		end else begin
			state <= next_state;
			if (pwr_cnt != 2'h3)
				pwr_cnt <= pwr_cnt + 2'h1;
			if (next_state != state)
				sec_cnt <= 16'h0000;
			else if (tick && sec_cnt != 16'hFFFF)
				sec_cnt <= sec_cnt + 16'h0001;
			if (tick)
				blink <= ~blink;
			if (ovh)
				ovh_lat <= 1'b1;
			else if (state == S_LOCK && next_state == S_OFF)
				ovh_lat <= 1'b0;
			if (state == S_OFF)
				brk <= 1'b1;
			else if (state == S_COOL || (state == S_START && sec_cnt >= `AHBS_T_BRK))
				brk <= 1'b0;
			if (state == S_OFF || state == S_HEAT)
				attempt <= 1'b0;
			else if (next_state == S_PURGE)
				attempt <= 1'b1;
		end
	end

	//------------------------------------------------------------------
	// heating demand and periodic pump limits
	//------------------------------------------------------------------
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			demand <= `AHBS_FAN_MAX;
			per_cnt <= 16'h0000;
			nine_cnt <= 16'h0000;
			minw_cnt <= 16'h0000;
		end else if (state != S_HEAT) begin
			demand <= `AHBS_FAN_MAX;
			per_cnt <= 16'h0000;
			minw_cnt <= 16'h0000;
			if (state == S_OFF || state == S_LOCK || state == S_COOL)
				nine_cnt <= 16'h0000;
		end else if (tick) begin
			if (!too_warm && intake_temp_i != setpoint)
				demand <= sat_up(demand, `AHBS_STEP_DEMAND, `AHBS_FAN_MAX);
			else if (too_warm)
				demand <= sat_dn(demand, `AHBS_STEP_DEMAND, `AHBS_FAN_MIN);
			if (too_warm && demand == `AHBS_FAN_MIN)
				minw_cnt <= minw_cnt + 16'h0001;
			else
				minw_cnt <= 16'h0000;
			per_cnt <= (per_cnt >= `AHBS_T_PERIOD - 16'h0001) ? 16'h0000
				: per_cnt + 16'h0001;
			nine_cnt <= nine_cnt + 16'h0001;
		end
	end

	//------------------------------------------------------------------
	// fan speed
	//------------------------------------------------------------------
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			fan_o <= 8'h00;
		end else if (next_state != state) begin
			case (next_state)
				S_START: fan_o <= brk ? `AHBS_FAN_MAX : fan_low;
				S_IDLE: fan_o <= `AHBS_FAN_MIN;
				S_FUEL: fan_o <= fan_low;
				S_PURGE: fan_o <= `AHBS_FAN_MAX;
				S_FAILRD: fan_o <= `AHBS_FAN_23;
				S_STAB: fan_o <= petrol ? fan_o : fan_mid;
				S_HEAT: fan_o <= `AHBS_FAN_MAX;
				S_COOL: fan_o <= `AHBS_FAN_23;
				S_SDOWN: fan_o <= fan_o;
				S_SMAX: fan_o <= `AHBS_FAN_MAX;
				S_RDOWN: fan_o <= `AHBS_FAN_23;
				default: fan_o <= 8'h00;
			endcase
		end else if (tick) begin
			case (state)
				S_START: begin
					if (sec_cnt >= `AHBS_T_BRK)
						fan_o <= fan_low;
				end
				S_FUEL: begin
					if (sec_cnt >= `AHBS_T_RAMP)
						fan_o <= sat_up(fan_o, `AHBS_STEP_RAMP, fan_mid);
				end
				S_STAB: begin
					if (petrol)
						fan_o <= sat_up(fan_o, `AHBS_STEP_RISE_P, `AHBS_FAN_MAX);
					else if (sec_cnt >= `AHBS_T_STAB_D)
						fan_o <= sat_up(fan_o, `AHBS_STEP_RISE_D, `AHBS_FAN_MAX);
				end
				S_HEAT: fan_o <= demand;
				S_SDOWN: fan_o <= sat_dn(fan_o, `AHBS_STEP_DOWN, `AHBS_FAN_23);
				default: fan_o <= fan_o;
			endcase
		end
	end

	//------------------------------------------------------------------
	// pump, glow plug and indicator
	//------------------------------------------------------------------
	always @* begin
		next_pump = 8'h00;
		next_glow = 1'b0;
		next_ind = 1'b0;
		case (state)
			S_START: begin
				next_glow = blink;
				next_ind = 1'b1;
			end
			S_FUEL: begin
				next_pump = `AHBS_PUMP_START;
				next_glow = 1'b1;
				next_ind = 1'b1;
			end
			S_PURGE: begin
				next_glow = 1'b1;
				next_ind = 1'b1;
			end
			S_STAB: begin
				next_pump = `AHBS_PUMP_START;
				next_glow = 1'b1;
				next_ind = 1'b1;
			end
			S_HEAT: begin
				next_ind = 1'b1;
				if (demand < `AHBS_KW12_LEVEL) begin
					if (per_cnt < `AHBS_T_PERIOD - `AHBS_T_CUT)
						next_pump = (demand < `AHBS_PUMP_MIN) ? `AHBS_PUMP_MIN : demand;
				end else if (!petrol && per_cnt >= `AHBS_T_PERIOD - `AHBS_T_REDUCE)
					next_pump = {1'b0, demand[7:1]};
				else
					next_pump = demand;
			end
			S_IDLE, S_COOL: next_ind = 1'b1;
			default: begin
				next_pump = 8'h00;
				next_glow = 1'b0;
				next_ind = 1'b0;
			end
		endcase
		if (ovh_lat)
			next_ind = blink;
	end

	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pump_o <= 8'h00;
			glow_o <= 1'b0;
			indicator_o <= 1'b0;
		end else begin
			pump_o <= (ovh || next_state == S_SDOWN) ? 8'h00 : next_pump;
			glow_o <= next_glow;
			indicator_o <= next_ind;
		end
	end

	//------------------------------------------------------------------
	// APB slave
	//------------------------------------------------------------------
	assign mapped = (paddr_i == `AHBS_REG_CTRL) || (paddr_i == `AHBS_REG_SETPT)
		|| (paddr_i == `AHBS_REG_STATUS) || (paddr_i == `AHBS_REG_OUTPUT)
		|| (paddr_i == `AHBS_REG_DEMAND);
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i && penable_i && !mapped;
	assign apb_wr = psel_i && penable_i && pwrite_i;
	assign apb_setup = psel_i && !penable_i;

	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			petrol <= `AHBS_CTRL_RST;
			setpoint <= `AHBS_SETPT_RST;
			prdata_o <= 32'h00000000;
		end else begin
			if (apb_wr && paddr_i == `AHBS_REG_CTRL)
				petrol <= pwdata_i[`AHBS_CTRL_PETROL];
			if (apb_wr && paddr_i == `AHBS_REG_SETPT)
				setpoint <= pwdata_i[7:0];
			if (apb_setup) begin
				case (paddr_i)
					`AHBS_REG_CTRL: prdata_o <= {31'h00000000, petrol};
					`AHBS_REG_SETPT: prdata_o <= {24'h000000, setpoint};
					`AHBS_REG_STATUS: prdata_o <= {12'h000, flame, sw_on, attempt,
						ovh_lat, 2'h0, state};
					`AHBS_REG_OUTPUT: prdata_o <= {14'h0000, indicator_o, glow_o,
						pump_o, fan_o};
					`AHBS_REG_DEMAND: prdata_o <= {24'h000000, demand};
					default: prdata_o <= 32'h00000000;
				endcase
			end
		end
	end
endmodule

// ### tb/ahbs_sequencer_assertions.sv
// Purpose: port-level checks of the burner sequencer
// Assumes: one clock domain, reset active high
// Notes: bound to every sequencer instance
module ahbs_seq_chk (
	input wire sys_clk_i, // clock
	input wire rst_i, // reset
	input wire psel_i, // select
	input wire penable_i, // enable
	input wire [7:0] paddr_i, // address
	input wire [31:0] prdata_o, // read data
	input wire pready_o, // ready
	input wire pslverr_o, // error
	input wire switch_on_i, // on/off control
	input wire overheat_i, // limiter
	input wire glow_o, // glow plug
	input wire indicator_o, // indicator
	input wire [7:0] fan_o, // fan speed
	input wire [7:0] pump_o // pump rate
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);

	a_reset_quiet:
	assert property ($fell(rst_i) |->
		(fan_o == 8'h00 && pump_o == 8'h00 && !glow_o && !indicator_o) [*3])
		else $error("outputs active right after reset");
	a_ready_const:
	assert property (pready_o)
		else $error("ready low");
	a_err_phase:
	assert property (pslverr_o |-> psel_i && penable_i)
		else $error("error outside access phase");
	a_err_decode:
	assert property (psel_i && penable_i && paddr_i[1:0] == 2'h0 |->
		pslverr_o == (paddr_i > 8'h10))
		else $error("address decode error wrong");
	a_rdata_hold:
	assert property (!psel_i |=> $stable(prdata_o))
		else $error("read data changed while idle");
	a_heat_cuts_pump:
	assert property (overheat_i [*5] |-> pump_o == 8'h00)
		else $error("pump runs during overheat");
	a_off_cuts_pump:
	assert property (!switch_on_i [*6] |-> pump_o == 8'h00)
		else $error("pump runs after switch-off");
	a_fan_stop_quiet:
	assert property (fan_o == 8'h00 [*2] |-> pump_o == 8'h00 && !glow_o)
		else $error("pump or glow active with fan stopped");
endmodule

bind ahbs_sequencer ahbs_seq_chk u_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
	.psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .switch_on_i(switch_on_i),
	.overheat_i(overheat_i), .glow_o(glow_o), .indicator_o(indicator_o),
	.fan_o(fan_o), .pump_o(pump_o));

// ### tb/ahbs_plant.sv
// Purpose: burner model producing the flame signal
// Assumes: flame needs fuel for LIGHT cycles while ignite_i is high
// Notes: flame outlives the pump by HOLD cycles
module ahbs_plant #(
	parameter int LIGHT = 240, // fuelled cycles until flame
	parameter int HOLD = 320 // cycles flame outlives fuel
) (
	input wire logic sys_clk_i, // clock
	input wire logic ignite_i, // mixture can ignite
	input wire logic [7:0] pump_i, // pump rate
	output logic flame_o // flame sensor
);
	timeunit 1ns;
	timeprecision 1ns;
	int run = 0;
	int dry = 0;
	initial flame_o = 1'h0;
	always @(posedge sys_clk_i) begin
		run <= (pump_i != 8'h00 && ignite_i) ? run + 1 : 0;
		dry <= (pump_i == 8'h00) ? dry + 1 : 0;
		if (run >= LIGHT)
			flame_o <= 1'h1;
		else if (dry >= HOLD || !ignite_i)
			flame_o <= 1'h0;
	end
endmodule

// ### tb/ahbs_sequencer_tb_top.sv
// Purpose: self-checking bench of the burner sequencer
// Assumes: one second shortened to S clocks
// Notes: phases are seen by polling the status register
module ahbs_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int S = 8; // clocks per second
	logic sys_clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0;
	logic switch_on_i = 1'h1, overheat_i = 1'h0, ignite = 1'h1;
	logic [7:0] intake_temp_i = 8'h40;
	logic [31:0] prdata_o, rdat;
	logic pready_o, pslverr_o, flame_i, indicator_o, glow_o, rerr, ind_prev;
	logic [7:0] fan_o, pump_o;
	int bad_count = 0, tests_run = 0, cyc = 0, ent = 0, tog = 0;

	ahbs_sequencer #(.TICK_CYCLES(S)) dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .switch_on_i(switch_on_i), .flame_i(flame_i),
		.overheat_i(overheat_i), .intake_temp_i(intake_temp_i),
		.indicator_o(indicator_o), .glow_o(glow_o), .fan_o(fan_o), .pump_o(pump_o));
	ahbs_plant #(.LIGHT(30 * S), .HOLD(40 * S)) u_plant (.sys_clk_i(sys_clk_i),
		.ignite_i(ignite), .pump_i(pump_o), .flame_o(flame_i));

	initial begin
		forever #50 sys_clk_i = ~sys_clk_i;
	end
	always @(posedge sys_clk_i) cyc <= cyc + 1;
	//----------------------------------------------------------------------
	// bus, compare and phase tasks
	//----------------------------------------------------------------------
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel_i <= 1'h1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge sys_clk_i);
		penable_i <= 1'h1;
		do @(posedge sys_clk_i); while (pready_o !== 1'h1);
		rdat = prdata_o;
		rerr = pslverr_o;
		psel_i <= 1'h0;
		penable_i <= 1'h0;
		@(posedge sys_clk_i);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_rng(input int got, input int lo, input int hi);
		tests_run++;
		if (got < lo || got > hi) begin
			bad_count++;
			$display("MISMATCH at %0t: got %h expected %h..%h", $time, got, lo, hi);
		end
	endtask
	task automatic wait_st(input int b, input int lim);
		int t0;
		t0 = cyc;
		apb(1'h0, 8'h08, 32'h0);
		while (rdat[b] !== 1'h1 && cyc - t0 < lim)
			apb(1'h0, 8'h08, 32'h0);
		ent = cyc;
		chk({31'h0, rdat[b]}, 32'h1);
	endtask
	// phase b follows the previous entry on the secs-th tick after it
	task automatic step(input int b, input int secs);
		int t0;
		t0 = ent;
		wait_st(b, (secs + 2) * S + 20);
		chk_rng(ent - t0, (secs - 1) * S - 4, secs * S + 4);
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	//----------------------------------------------------------------------
	// scenarios
	//----------------------------------------------------------------------
	initial begin
		repeat (10) @(posedge sys_clk_i);
		rst_i <= 1'h0;
		wait_st(2, 40);
		switch_on_i <= 1'h0;
		wait_st(1, 40);
		apb(1'h0, 8'h00, 32'h0);
		chk(rdat, 32'h0);
		apb(1'h0, 8'h04, 32'h0);
		chk(rdat, 32'h80);
		apb(1'h0, 8'h14, 32'h0);
		chk({rerr, rdat[30:0]}, 32'h80000000);
		apb(1'h1, 8'h08, 32'hFFFFFFFF);
		apb(1'h1, 8'h04, 32'h50);
		apb(1'h0, 8'h08, 32'h0);
		chk(rdat[13:0], 32'h2);
		apb(1'h0, 8'h04, 32'h0);
		chk(rdat, 32'h50);
		intake_temp_i <= 8'h70;
		switch_on_i <= 1'h1;
		wait_st(3, 40);
		chk({fan_o != 8'h00, pump_o, glow_o}, 32'h200);
		intake_temp_i <= 8'h40;
		wait_st(4, 40);
		switch_on_i <= 1'h0;
		wait_st(1, 40);
		chk({fan_o, indicator_o}, 32'h0);
		switch_on_i <= 1'h1;
		wait_st(4, 40);
		repeat (2) @(posedge sys_clk_i);
		chk({fan_o, indicator_o}, 32'h1FF);
		repeat (2 * S) @(posedge sys_clk_i);
		chk(fan_o, 8'h4D);
		step(5, 20);
		chk(pump_o, 8'h40);
		repeat (28 * S) @(posedge sys_clk_i);
		chk(fan_o > 8'h4D, 32'h1);
		wait_st(8, 10 * S);
		chk(glow_o, 1'h1);
		step(9, 37);
		chk(glow_o, 1'h0);
		intake_temp_i <= 8'h70;
		wait_st(10, 40 * S);
		chk(pump_o, 8'h00);
		chk(fan_o, 8'hAA);
		step(3, 155);
		chk({fan_o, indicator_o}, 32'h67);
		intake_temp_i <= 8'h40;
		wait_st(4, 40);
		chk(fan_o, 8'h4D);
		wait_st(9, 100 * S);
		switch_on_i <= 1'h0;
		repeat (6) @(posedge sys_clk_i);
		chk({indicator_o, pump_o}, 32'h0);
		wait_st(11, 40);
		step(12, 35);
		chk(fan_o, 8'hFF);
		step(13, 60);
		chk(fan_o, 8'hAA);
		ignite <= 1'h0;
		switch_on_i <= 1'h1;
		step(4, 120);
		step(5, 20);
		step(6, 120);
		chk({fan_o, pump_o, glow_o}, 32'h1FE01);
		step(4, 30);
		step(5, 20);
		step(7, 80);
		chk(fan_o, 8'hAA);
		step(2, 120);
		switch_on_i <= 1'h0;
		wait_st(1, 40);
		apb(1'h1, 8'h00, 32'h1);
		switch_on_i <= 1'h1;
		wait_st(4, 40);
		step(5, 15);
		overheat_i <= 1'h1;
		repeat (6) @(posedge sys_clk_i);
		chk({fan_o != 8'h00, pump_o}, 32'h100);
		ind_prev = indicator_o;
		for (int i = 0; i < 4 * S; i++) begin
			@(posedge sys_clk_i);
			if (indicator_o !== ind_prev)
				tog++;
			ind_prev = indicator_o;
		end
		chk_rng(tog, 2, 8);
		wait_st(2, 300 * S);
		overheat_i <= 1'h0;
		switch_on_i <= 1'h0;
		wait_st(1, 40);
		give_verdict();
	end
	initial begin
		repeat (30000) @(posedge sys_clk_i);
		bad_count++;
		give_verdict();
	end
endmodule
